// *** hw/scr_defs.svh ***
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_OFF_MISC 8'h34
`define SCR_OFF_PINSEL 8'h30
`define SCR_OFF_IRQ 8'h3C
`define SCR_MISC_RESET 32'h0000_0001
`define SCR_PINSEL_RESET 32'h0000_0000
`define SCR_IRQ_RESET 8'h00
`define SCR_B_WIN5_WIDE 15
`define SCR_B_BOOT_INV 14
`define SCR_B_WIN4_NOWAIT 13
`define SCR_B_IO1_NOWAIT 12
`define SCR_B_IO0_NOWAIT 11
`define SCR_B_DOC_NOWAIT 10
`define SCR_B_ROM_NOWAIT 9
`define SCR_B_IO1_WIDE 8
`define SCR_B_IO0_WIDE 7
`define SCR_B_DOC_WIDE 6
`define SCR_B_WIN4_WIDE 5
`define SCR_B_IR_EN 4
`define SCR_B_BOOT_STAT 3
`define SCR_B_WIN5_NOWAIT 2
`define SCR_B_DISC 0
`define SCR_B_MON 30
`define SCR_MISC_WMASK 32'h0000_FFF5
`define SCR_B_PIN_WIN4 1
`define SCR_B_PIN_CMD_LO 2
`define SCR_B_PIN_CMD_HI 21
`endif

// *** hw/scr_pkg.sv ***
package scr_pkg;
	// chip select order: win5, win4, io1, io0, diskchip, bootrom
	typedef struct packed {
		logic win5;
		logic win4;
		logic io1;
		logic io0;
		logic diskchip;
		logic bootrom;
	} scr_cs_t;
	typedef enum logic [1:0] {
		SCR_CMD_GPIO = 2'b00,
		SCR_CMD_IOCS = 2'b01,
		SCR_CMD_IOW = 2'b10,
		SCR_CMD_DOC = 2'b11
	} scr_cmd_t;
	typedef enum logic [1:0] {
		SCR_DISC_BOTH_PROG = 2'b00,
		SCR_DISC_RD_LINE = 2'b01,
		SCR_DISC_LINE = 2'b10
	} scr_disc_t;
endpackage

// *** hw/scr_config_regs.sv ***
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "scr_defs.svh"
// Overview of operation
// - pin-select bit 1 picks GPIO or window-4 chip select on its ball
// - bit 30 reads the monitor strap latched after power-on reset
// - bit 15 picks 8 or 16 bit cycles for window-5 select
// - bit 14 inverts the boot width reading
// - bit 13 enables zero wait states for window-4 select
// - bits 12 and 11 enable zero waits for io selects 1 and 0
// - bits 10 and 9 enable zero waits for diskchip and boot ROM
// - bits 8 and 7 pick widths of io selects 1 and 0
// - bit 6 picks diskchip select width
// - bit 5 picks window-4 select width
// - bit 3 reads boot width strap, read only
// - bit 2 enables zero wait states for window-5 select
// - disconnect bit resets to one
// - low nibble zero disables, else picks IRQ line, two codes reserved
// - routed interrupt drives a shareable open-drain style request
module scr_config_regs (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic bus_monitor_strap,
	input wire logic boot_width_strap,
	input wire logic [1:0] procDiscField,
	input wire logic timerIrq,
	input wire scr_pkg::scr_cs_t csActive,
	output logic zero_wait_ctl_n,
	output logic cycleWide,
	output scr_pkg::scr_cs_t csWide,
	output scr_pkg::scr_cs_t csNowait,
	output logic win4_cs_ball_select,
	output scr_pkg::scr_cmd_t cmdBallMode,
	output logic irTxOe,
	output scr_pkg::scr_disc_t discPolicy,
	output logic [15:0] irqOut,
	output logic [15:0] irqOe,
	output logic bootWide
);
	import scr_pkg::*;
	logic [31:0] misc_q;
	logic [31:0] pin_q;
	logic [7:0] irq_q;
	logic [31:0] rdata_q;
	logic strapDone_q;
	logic monStrap_q;
	logic bootStrap_q;
	logic [3:0] timer_irq_code;
	logic [31:0] miscRead;
	logic [31:0] rdMux;
	logic hitMisc;
	logic hitPin;
	logic hitIrq;
	logic codeReserved;
	logic func_cmd_select_low;
	logic func_cmd_select_high;

	localparam int NumCs = 6;
	localparam int NumIrq = 16;

	// next-state values, one per flop group
	logic [31:0] misc_d;
	logic [31:0] pin_d;
	logic [7:0] irq_d;
	logic [31:0] rdata_d;
	logic strapDone_d;
	logic monStrap_d;
	logic bootStrap_d;

	// qualified bus strobes
	logic wrMisc;
	logic wrPin;
	logic wrIrq;
	logic rdAny;
	// straps are taken once, so later pin noise cannot change status bits
	logic strapTake;

	// read words per register
	logic [31:0] pinRead;
	logic [31:0] irqRead;

	// misc register fields, all plain copies of register bits
	logic win5Wide;
	logic win4Wide;
	logic io1Wide;
	logic io0Wide;
	logic diskWide;
	logic win5Nowait;
	logic win4Nowait;
	logic io1Nowait;
	logic io0Nowait;
	logic diskNowait;
	logic romNowait;
	logic bootInvert;
	logic irDrive;
	logic discBit;
	// processor side may only force the line policy on, through procDiscField bit 1
	logic lineForced;

	// per-select vectors, bit 0 is bootrom as in scr_cs_t
	logic [NumCs-1:0] activeVec;
	logic [NumCs-1:0] wideVec;
	logic [NumCs-1:0] nowaitVec;
	logic [NumCs-1:0] wideHit;
	logic [NumCs-1:0] nowaitHit;

	// interrupt routing
	logic codeDisable;
	logic routeOn;
	logic [NumIrq-1:0] lineSel;

	assign hitMisc = (regAddr == `SCR_OFF_MISC);
	assign hitPin = (regAddr == `SCR_OFF_PINSEL);
	assign hitIrq = (regAddr == `SCR_OFF_IRQ);
	assign timer_irq_code = irq_q[3:0];
	assign func_cmd_select_low = pin_q[`SCR_B_PIN_CMD_LO];
	assign func_cmd_select_high = pin_q[`SCR_B_PIN_CMD_HI];

	// strobes need no gating by clkEn here, the flops hold while it is low
	assign wrMisc = regWr && hitMisc;
	assign wrPin = regWr && hitPin;
	assign wrIrq = regWr && hitIrq;
	assign rdAny = regRd;
	assign strapTake = !strapDone_q;

	// strap status bits inserted, bits 31 and 29:16 read zero
	always_comb begin
		miscRead = misc_q & `SCR_MISC_WMASK;
		miscRead[`SCR_B_MON] = monStrap_q;
		miscRead[`SCR_B_BOOT_STAT] = bootStrap_q;
	end

	assign pinRead = pin_q;
	// upper nibble of the route byte always reads back zero
	assign irqRead = {24'h00_0000, irq_q};
	// unmapped offsets read zero
	assign rdMux = hitMisc ? miscRead :
		hitPin ? pinRead :
		hitIrq ? irqRead : 32'h0000_0000;

	// straps caught on the first enabled edge after reset release
	assign strapDone_d = 1'b1;
	assign monStrap_d = strapTake ? bus_monitor_strap : monStrap_q;
	assign bootStrap_d = strapTake ? boot_width_strap : bootStrap_q;

	// marks that the straps have been taken
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			strapDone_q <= 1'b0;
		end else if (clkEn) begin
			strapDone_q <= strapDone_d;
		end
	end

	// monitor strap status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			monStrap_q <= 1'b0;
		end else if (clkEn) begin
			monStrap_q <= monStrap_d;
		end
	end

	// boot width strap status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bootStrap_q <= 1'b0;
		end else if (clkEn) begin
			bootStrap_q <= bootStrap_d;
		end
	end

	// reserved bits masked so stray writes never reach logic
	assign misc_d = wrMisc ? (regWdata & `SCR_MISC_WMASK) : misc_q;
	assign pin_d = wrPin ? regWdata : pin_q;
	// upper nibble kept as read
	assign irq_d = wrIrq ? {irq_q[7:4], regWdata[3:0]} : irq_q;
	// read data stands one cycle, then falls back to zero
	assign rdata_d = rdAny ? rdMux : 32'h0000_0000;

	// reset leaves the disconnect bit set, everything else clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			misc_q <= `SCR_MISC_RESET;
		end else if (clkEn) begin
			misc_q <= misc_d;
		end
	end

	// pin function select word
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_q <= `SCR_PINSEL_RESET;
		end else if (clkEn) begin
			pin_q <= pin_d;
		end
	end

	// timer interrupt route byte
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_q <= `SCR_IRQ_RESET;
		end else if (clkEn) begin
			irq_q <= irq_d;
		end
	end

	// registered read data
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
		end else if (clkEn) begin
			rdata_q <= rdata_d;
		end
	end

	assign regRdata = rdata_q;

	// boot select width follows the strap unless software inverts it
	assign bootWide = bootStrap_q ^ bootInvert;

	// width bits: 0 gives 8-bit cycles, 1 gives 16-bit cycles
	assign win5Wide = misc_q[`SCR_B_WIN5_WIDE];
	assign win4Wide = misc_q[`SCR_B_WIN4_WIDE];
	assign io1Wide = misc_q[`SCR_B_IO1_WIDE];
	assign io0Wide = misc_q[`SCR_B_IO0_WIDE];
	assign diskWide = misc_q[`SCR_B_DOC_WIDE];
	// nowait bits: 1 asks for zero wait states on that select
	assign win5Nowait = misc_q[`SCR_B_WIN5_NOWAIT];
	assign win4Nowait = misc_q[`SCR_B_WIN4_NOWAIT];
	assign io1Nowait = misc_q[`SCR_B_IO1_NOWAIT];
	assign io0Nowait = misc_q[`SCR_B_IO0_NOWAIT];
	assign diskNowait = misc_q[`SCR_B_DOC_NOWAIT];
	assign romNowait = misc_q[`SCR_B_ROM_NOWAIT];
	assign bootInvert = misc_q[`SCR_B_BOOT_INV];
	assign irDrive = misc_q[`SCR_B_IR_EN];
	assign discBit = misc_q[`SCR_B_DISC];
	assign lineForced = procDiscField[1];

	assign wideVec = {win5Wide, win4Wide, io1Wide, io0Wide, diskWide, bootWide};
	assign nowaitVec = {win5Nowait, win4Nowait, io1Nowait, io0Nowait, diskNowait, romNowait};
	assign activeVec = csActive;
	assign csWide = wideVec;
	assign csNowait = nowaitVec;

	// per-cycle controls for whichever select the bus is driving
	genvar gc;
	generate
		for (gc = 0; gc < NumCs; gc++) begin : gCs
			assign wideHit[gc] = activeVec[gc] && wideVec[gc];
			assign nowaitHit[gc] = activeVec[gc] && nowaitVec[gc];
		end
	endgenerate
	// zero-wait request is active low, so any hit pulls it down
	assign zero_wait_ctl_n = ~|nowaitHit;
	assign cycleWide = |wideHit;

	assign win4_cs_ball_select = pin_q[`SCR_B_PIN_WIN4];
	assign cmdBallMode = scr_cmd_t'({func_cmd_select_high, func_cmd_select_low});
	assign irTxOe = irDrive;

	assign discPolicy = lineForced ? SCR_DISC_LINE :
		(discBit ? SCR_DISC_RD_LINE : SCR_DISC_BOTH_PROG);

	// code zero turns routing off, two codes are held back and drive nothing
	assign codeReserved = (timer_irq_code == 4'h2) || (timer_irq_code == 4'hD);
	assign codeDisable = (timer_irq_code == 4'h0);
	assign routeOn = timerIrq && !codeReserved && !codeDisable;

	// active-low request, driven only while asserted so the line stays shareable
	genvar gi;
	generate
		for (gi = 0; gi < NumIrq; gi++) begin : gIrq
			assign lineSel[gi] = (timer_irq_code == 4'(gi));
			assign irqOut[gi] = 1'b0;
			assign irqOe[gi] = routeOn && lineSel[gi];
		end
	endgenerate
endmodule

// *** verif/scr_config_checker_properties.sv ***
`timescale 1ns/1ps
module scr_config_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire scr_pkg::scr_cs_t csActive,
	input wire scr_pkg::scr_cs_t csWide,
	input wire scr_pkg::scr_cs_t csNowait,
	input wire logic zero_wait_ctl_n,
	input wire logic cycleWide,
	input wire logic irTxOe,
	input wire logic timerIrq,
	input wire logic [15:0] irqOut,
	input wire logic [15:0] irqOe
);
	import scr_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire wrMisc = regWr && clkEn && regAddr == 8'h34;
	wire rdMisc = regRd && clkEn && regAddr == 8'h34;
	resv_zero_a: assert property (rdMisc |=> regRdata[31] == 1'h0)
		else $error("reserved bit set");
	zero_wait_a: assert property (zero_wait_ctl_n == !(|(csActive & csNowait)))
		else $error("zero wait wrong");
	cycle_wide_a: assert property (cycleWide == |(csActive & csWide))
		else $error("width wrong");
	nowait_take_a: assert property (wrMisc |=> csNowait.win4 == $past(regWdata[13]))
		else $error("nowait late");
	ir_drive_a: assert property (wrMisc |=> irTxOe == $past(regWdata[4]))
		else $error("ir drive wrong");
	irq_share_a: assert property (irqOut == 16'h0)
		else $error("irq level wrong");
	irq_idle_a: assert property (!timerIrq |-> irqOe == 16'h0)
		else $error("irq without source");
	irq_single_a: assert property ($onehot0(irqOe))
		else $error("irq on two lines");
endmodule

// *** verif/scr_bus_dev.sv ***
`timescale 1ns/1ps
module scr_bus_dev (
	input wire logic ref_clk,
	input wire logic reset,
	output scr_pkg::scr_cs_t csActive
);
	import scr_pkg::*;
	logic [2:0] slot_q;
	// one select per bus cycle, with idle slots between rounds
	always_ff @(posedge ref_clk) begin
		if (reset)
			slot_q <= 3'h0;
		else
			slot_q <= slot_q + 3'h1;
	end
	assign csActive = (slot_q > 3'h5) ? 6'h00 : 6'h01 << slot_q;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import scr_pkg::*;
	logic ref_clk = 1'h0, reset = 1'h1, clkEn = 1'h1, regWr = 1'h0, regRd = 1'h0;
	logic timerIrq = 1'h0, bus_monitor_strap = 1'h1, boot_width_strap = 1'h1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, v;
	logic [1:0] procDiscField = 2'h0;
	logic [5:0] nw, wd;
	logic [15:0] irqOut, irqOe;
	logic zero_wait_ctl_n, cycleWide, win4_cs_ball_select, irTxOe, bootWide;
	scr_cs_t csActive, csWide, csNowait;
	scr_cmd_t cmdBallMode;
	scr_disc_t discPolicy;
	int fail_count = 0, checked = 0, seed = 42611;
	scr_config_regs uut (
		.ref_clk(ref_clk),
		.reset(reset),
		.clkEn(clkEn),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWr(regWr),
		.regRd(regRd),
		.regRdata(regRdata),
		.bus_monitor_strap(bus_monitor_strap),
		.boot_width_strap(boot_width_strap),
		.procDiscField(procDiscField),
		.timerIrq(timerIrq),
		.csActive(csActive),
		.zero_wait_ctl_n(zero_wait_ctl_n),
		.cycleWide(cycleWide),
		.csWide(csWide),
		.csNowait(csNowait),
		.win4_cs_ball_select(win4_cs_ball_select),
		.cmdBallMode(cmdBallMode),
		.irTxOe(irTxOe),
		.discPolicy(discPolicy),
		.irqOut(irqOut),
		.irqOe(irqOe),
		.bootWide(bootWide)
	);
	scr_bus_dev dev (.ref_clk(ref_clk), .reset(reset), .csActive(csActive));
	initial forever #50 ref_clk = ~ref_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge ref_clk);
		regWr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1 chk(regRdata, e);
	endtask
	task give_verdict;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		rd(8'h34, 32'h4000_0009);
		rd(8'h40, 32'h0);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed) & 32'h0000_FFFF;
			nw = {v[2], v[13], v[12], v[11], v[10], v[9]};
			wd = {v[15], v[5], v[8], v[7], v[6], ~v[14]};
			@(posedge ref_clk);
			procDiscField <= i[1:0];
			wr(8'h34, v);
			rd(8'h34, v & 32'hFFF5 | 32'h4000_0008);
			chk({csWide, csNowait, irTxOe, bootWide, discPolicy}, {v[15], v[5], v[8], v[7], v[6],
				~v[14], v[2], v[13], v[12], v[11], v[10], v[9], v[4], ~v[14],
				(i[1] ? 2'h2 : {1'h0, v[0]})});
			repeat (8) begin
				@(posedge ref_clk);
				#1 chk({zero_wait_ctl_n, cycleWide}, {~|(csActive & nw), |(csActive & wd)});
			end
			wr(8'h30, {10'h0, v[0], 18'h0, v[2:1], 1'h0});
			#1 chk({win4_cs_ball_select, cmdBallMode}, {v[1], v[0], v[2]});
		end
		@(posedge ref_clk);
		timerIrq <= 1'h1;
		for (int c = 0; c < 16; c++) begin
			wr(8'h3C, c);
			rd(8'h3C, c);
			chk(irqOe, (c == 0 || c == 2 || c == 13) ? 0 : 32'h1 << c);
		end
		@(posedge ref_clk);
		timerIrq <= 1'h0;
		@(posedge ref_clk);
		#1 chk(irqOe, 32'h0);
		chk(irqOut, 32'h0);
		@(posedge ref_clk);
		reset <= 1'h1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		rd(8'h3C, 32'h0);
		rd(8'h34, 32'h4000_0009);
		give_verdict;
	end
	initial begin
		#1000000;
		fail_count++;
		give_verdict;
	end
endmodule
bind scr_config_regs scr_config_checker chk_i (.*);
